// ===== design/wakeup_edge_and_flag_clear.sv
// Wake-up input seven edge selection, pending request flags with a
// write-only vector clear register, status/mask interrupt, Avalon-MM slave.
// Assumes one clock, a synchronous active-low reset, and source request
// pulses that come from logic on the same clock.
//
// Contract
// - Mode bit clear: both edges raise request
// - Mode set, edge clear: falling edge only
// - Mode set, edge set: rising edge only
// - Clear write clears source with matching vector
// - Code 0AH clears external request zero
// - Clear register write-only byte at F8H

`timescale 1ns/10ps
`default_nettype none

module wakeup_edge_and_flag_clear #(
    parameter int NUM_SRC = 4,
    parameter int WAKE_SRC = 1,
    parameter logic [NUM_SRC*8-1:0] SRC_VECTORS = {
        wakeup_clear_pkg::VEC_SRC_THREE,
        wakeup_clear_pkg::VEC_SRC_TWO,
        wakeup_clear_pkg::VEC_WAKE_SEVEN,
        wakeup_clear_pkg::VEC_EXT_ZERO
    }
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic ce,
    input wire logic [7:0] address,
    input wire logic read,
    input wire logic write,
    input wire logic [31:0] writedata,
    input wire logic [3:0] byteenable,
    output logic [31:0] readdata,
    output logic waitrequest,
    input wire logic wakeInputPinSeven,
    input wire logic [NUM_SRC-1:0] srcRequest,
    output logic [NUM_SRC-1:0] pendingFlags,
    output logic wakeupRequestSeven,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////
    // State

    logic [1:0] pinSync_r;
    logic [1:0] pinSync_nxt;
    logic pinPrev_r;
    logic pinPrev_nxt;
    logic wakeMode_r;
    logic wakeMode_nxt;
    logic wakeEdge_r;
    logic wakeEdge_nxt;
    logic [NUM_SRC-1:0] pending_r;
    logic [NUM_SRC-1:0] pending_nxt;
    logic [wakeup_clear_pkg::STAT_W-1:0] status_r;
    logic [wakeup_clear_pkg::STAT_W-1:0] status_nxt;
    logic [wakeup_clear_pkg::STAT_W-1:0] mask_r;
    logic [wakeup_clear_pkg::STAT_W-1:0] mask_nxt;
    logic wakeReq_r;
    logic wakeReq_nxt;
    logic irq_r;
    logic irq_nxt;
    logic waitrequest_r;
    logic waitrequest_nxt;
    logic [31:0] readdata_r;
    logic [31:0] readdata_nxt;

    ////////////////////////////////////////////////////////////////////////////
    // Combinational helpers

    logic pinRise;
    logic pinFall;
    logic wakeEvent;
    logic take;
    logic takeWrite;
    logic takeRead;
    logic clearWrite;
    logic [NUM_SRC-1:0] matchVec;
    logic [NUM_SRC-1:0] setVec;
    logic [wakeup_clear_pkg::STAT_W-1:0] statEvents;

    // Only the second sync stage and the delayed copy feed the detector
    always_comb begin
        pinSync_nxt = {pinSync_r[0], wakeInputPinSeven};
        pinPrev_nxt = pinSync_r[1];
        pinRise = pinSync_r[1] & ~pinPrev_r;
        pinFall = ~pinSync_r[1] & pinPrev_r;
        if (!wakeMode_r) begin
            wakeEvent = pinRise | pinFall;
        end else if (!wakeEdge_r) begin
            wakeEvent = pinFall;
        end else begin
            wakeEvent = pinRise;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Bus slave: one wait cycle, work done at the edge that drops waitrequest

    always_comb begin
        take = (read | write) & waitrequest_r & ce;
        takeWrite = take & write & byteenable[0];
        takeRead = take & read;
        clearWrite = takeWrite && (address == wakeup_clear_pkg::ADDR_CLEAR);
        for (int i = 0; i < NUM_SRC; i++) begin
            matchVec[i] = (SRC_VECTORS[i*8 +: 8] == writedata[7:0]);
        end
        // Handshake flop runs even with ce low so an issued ack never repeats
        waitrequest_nxt = ~take;
        readdata_nxt = readdata_r;
        if (takeRead) begin
            unique case (address)
                wakeup_clear_pkg::ADDR_MODE:
                    readdata_nxt = 32'(wakeMode_r) << wakeup_clear_pkg::MODE_BIT_SEVEN;
                wakeup_clear_pkg::ADDR_EDGE:
                    readdata_nxt = 32'(wakeEdge_r) << wakeup_clear_pkg::EDGE_BIT_SEVEN;
                wakeup_clear_pkg::ADDR_PEND:
                    readdata_nxt = 32'(pending_r);
                wakeup_clear_pkg::ADDR_STAT:
                    readdata_nxt = 32'(status_r);
                wakeup_clear_pkg::ADDR_MASK:
                    readdata_nxt = 32'(mask_r);
                // Write-only clear location and unmapped space read zero
                default:
                    readdata_nxt = wakeup_clear_pkg::READ_ZERO;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Control registers, pending flags, status and interrupt

    always_comb begin
        wakeMode_nxt = wakeMode_r;
        wakeEdge_nxt = wakeEdge_r;
        mask_nxt = mask_r;
        if (takeWrite && address == wakeup_clear_pkg::ADDR_MODE) begin
            wakeMode_nxt = writedata[wakeup_clear_pkg::MODE_BIT_SEVEN];
        end
        if (takeWrite && address == wakeup_clear_pkg::ADDR_EDGE) begin
            wakeEdge_nxt = writedata[wakeup_clear_pkg::EDGE_BIT_SEVEN];
        end
        if (takeWrite && address == wakeup_clear_pkg::ADDR_MASK) begin
            mask_nxt = writedata[wakeup_clear_pkg::STAT_W-1:0];
        end
        setVec = srcRequest;
        setVec[WAKE_SRC] = srcRequest[WAKE_SRC] | wakeEvent;
        // A request in the clearing cycle survives: set wins over clear
        pending_nxt = pending_r;
        if (clearWrite) begin
            pending_nxt = pending_r & ~matchVec;
        end
        pending_nxt = pending_nxt | setVec;
        statEvents = '0;
        statEvents[wakeup_clear_pkg::STAT_WAKE] = wakeEvent;
        statEvents[wakeup_clear_pkg::STAT_NOMATCH] = clearWrite & ~(|matchVec);
        status_nxt = status_r;
        if (takeWrite && address == wakeup_clear_pkg::ADDR_STAT) begin
            status_nxt = status_r & ~writedata[wakeup_clear_pkg::STAT_W-1:0];
        end
        status_nxt = status_nxt | statEvents;
        wakeReq_nxt = wakeEvent;
        irq_nxt = |(status_nxt & mask_nxt);
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            waitrequest_r <= 1'h1;
        end else begin
            waitrequest_r <= waitrequest_nxt;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            // Sync stages reset low: a pin high at release reads as a rising edge
            pinSync_r <= 2'h0;
            pinPrev_r <= 1'h0;
            wakeMode_r <= wakeup_clear_pkg::MODE_RST;
            wakeEdge_r <= wakeup_clear_pkg::EDGE_RST;
            pending_r <= '0;
            status_r <= wakeup_clear_pkg::STAT_RST;
            mask_r <= wakeup_clear_pkg::MASK_RST;
            wakeReq_r <= 1'h0;
            irq_r <= 1'h0;
            readdata_r <= wakeup_clear_pkg::READ_ZERO;
        end else if (ce) begin
            pinSync_r <= pinSync_nxt;
            pinPrev_r <= pinPrev_nxt;
            wakeMode_r <= wakeMode_nxt;
            wakeEdge_r <= wakeEdge_nxt;
            pending_r <= pending_nxt;
            status_r <= status_nxt;
            mask_r <= mask_nxt;
            wakeReq_r <= wakeReq_nxt;
            irq_r <= irq_nxt;
            readdata_r <= readdata_nxt;
        end
    end

    assign readdata = readdata_r;
    assign waitrequest = waitrequest_r;
    assign pendingFlags = pending_r;
    assign wakeupRequestSeven = wakeReq_r;
    assign irq = irq_r;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);

    bus_ack_a: assert property ((read || write) && waitrequest && ce |=> !waitrequest)
        else $error("request not acknowledged after one wait cycle");

    bus_single_a: assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low for more than one cycle");

    both_edges_a: assert property (ce && !wakeMode_r && (pinRise || pinFall) |=> wakeupRequestSeven)
        else $error("edge missed in both-edge mode");

    fall_only_a: assert property (ce && wakeMode_r && !wakeEdge_r |=> wakeupRequestSeven == $past(pinFall))
        else $error("falling-edge mode responded wrongly");

    rise_only_a: assert property (ce && wakeMode_r && wakeEdge_r |=> wakeupRequestSeven == $past(pinRise))
        else $error("rising-edge mode responded wrongly");

    clear_match_a: assert property (clearWrite && !(|(matchVec & setVec))
        |=> (pendingFlags & $past(matchVec)) == '0)
        else $error("matching pending flag not cleared");

    ext_zero_a: assert property (clearWrite && writedata[7:0] == wakeup_clear_pkg::VEC_EXT_ZERO
        && !setVec[0] |=> !pendingFlags[0])
        else $error("code 0A did not clear external request zero");

    nomatch_keep_a: assert property (clearWrite && matchVec == '0
        |=> (pendingFlags & ~$past(setVec)) == ($past(pendingFlags) & ~$past(setVec)))
        else $error("unmatched clear code changed flags");

    clear_readzero_a: assert property (take && read && address == wakeup_clear_pkg::ADDR_CLEAR
        |=> readdata == '0 ##1 waitrequest)
        else $error("clear register did not read as zero");

    set_wins_a: assert property (ce && setVec != '0 |=> (pendingFlags & $past(setVec)) == $past(setVec))
        else $error("source request lost");

    irq_level_a: assert property (irq == |(status_r & mask_r))
        else $error("interrupt level disagrees with status and mask");

    ////////////////////////////////////////////////////////////////////////////
    // Enable, pin and register checks

    // Low enable must freeze every registered output except waitrequest
    freeze_flags_a: assert property (!ce |=> $stable(pendingFlags) && $stable(irq))
        else $error("flags or interrupt moved while enable low");

    freeze_bus_a: assert property (!ce |=> $stable(wakeupRequestSeven) && $stable(readdata))
        else $error("request pulse or read data moved while enable low");

    quiet_pin_a: assert property (ce && !pinRise && !pinFall |=> !wakeupRequestSeven)
        else $error("wake request without a pin edge");

    wake_pending_a: assert property (ce && wakeEvent |=> pendingFlags[WAKE_SRC])
        else $error("wake edge did not set its pending flag");

    wake_status_a: assert property (ce && wakeEvent |=> status_r[wakeup_clear_pkg::STAT_WAKE])
        else $error("wake edge did not set its status bit");

    // Writing a one clears, unless the event repeats in that cycle
    status_clear_a: assert property (takeWrite && address == wakeup_clear_pkg::ADDR_STAT && !wakeEvent
        && writedata[wakeup_clear_pkg::STAT_WAKE] |=> !status_r[wakeup_clear_pkg::STAT_WAKE])
        else $error("wake status bit not cleared by writing one");

    nomatch_status_a: assert property (clearWrite && matchVec == '0
        |=> status_r[wakeup_clear_pkg::STAT_NOMATCH])
        else $error("unmatched clear code not flagged");

    clear_keeps_ctrl_a: assert property (clearWrite |=> $stable(wakeMode_r) && $stable(wakeEdge_r)
        && $stable(mask_r))
        else $error("clear write disturbed a control register");

    lane_ignore_a: assert property (take && write && !byteenable[0]
        |=> $stable(wakeMode_r) && $stable(wakeEdge_r) && $stable(mask_r))
        else $error("write without lane zero changed a register");

    mode_write_a: assert property (takeWrite && address == wakeup_clear_pkg::ADDR_MODE
        |=> wakeMode_r == $past(writedata[wakeup_clear_pkg::MODE_BIT_SEVEN]))
        else $error("mode bit write not taken");

    edge_write_a: assert property (takeWrite && address == wakeup_clear_pkg::ADDR_EDGE
        |=> wakeEdge_r == $past(writedata[wakeup_clear_pkg::EDGE_BIT_SEVEN]))
        else $error("edge bit write not taken");

    mask_write_a: assert property (takeWrite && address == wakeup_clear_pkg::ADDR_MASK
        |=> mask_r == $past(writedata[wakeup_clear_pkg::STAT_W-1:0]))
        else $error("mask write not taken");

    read_stands_a: assert property (!takeRead |=> $stable(readdata))
        else $error("read data changed without a read");

    pend_read_a: assert property (takeRead && address == wakeup_clear_pkg::ADDR_PEND
        |=> readdata[NUM_SRC-1:0] == $past(pendingFlags))
        else $error("pending flags read back wrong");

endmodule : wakeup_edge_and_flag_clear

`default_nettype wire

// ===== pkg/wakeup_clear_pkg.sv
// Register map, field positions and reset values for the wake-up edge
// selection and request flag clear block.
// Assumes a 32-bit Avalon-MM slave with byte addresses, one register per word.

`default_nettype none

package wakeup_clear_pkg;

    // Byte offsets on the register bus
    localparam logic [7:0] ADDR_MODE = 8'h00;
    localparam logic [7:0] ADDR_EDGE = 8'h04;
    localparam logic [7:0] ADDR_PEND = 8'h08;
    localparam logic [7:0] ADDR_STAT = 8'h0C;
    localparam logic [7:0] ADDR_MASK = 8'h10;
    localparam logic [7:0] ADDR_CLEAR = 8'hF8;

    // Field positions
    localparam int MODE_BIT_SEVEN = 7;
    localparam int EDGE_BIT_SEVEN = 7;
    localparam int STAT_WAKE = 0;
    localparam int STAT_NOMATCH = 1;
    localparam int STAT_W = 2;

    // Reset values
    localparam logic MODE_RST = 1'h0;
    localparam logic EDGE_RST = 1'h0;
    localparam logic [STAT_W-1:0] STAT_RST = 2'h0;
    localparam logic [STAT_W-1:0] MASK_RST = 2'h0;
    localparam logic [31:0] READ_ZERO = 32'h0000_0000;

    // Vector codes of the clearable sources
    localparam logic [7:0] VEC_EXT_ZERO = 8'h0A;
    localparam logic [7:0] VEC_WAKE_SEVEN = 8'h0B;
    localparam logic [7:0] VEC_SRC_TWO = 8'h0C;
    localparam logic [7:0] VEC_SRC_THREE = 8'h0D;

endpackage : wakeup_clear_pkg

`default_nettype wire

// ===== verification/cpu_model.sv
// Processor core model: Avalon-MM master on the register port.
// Assumes its tasks are called just after a rising clock edge.
`timescale 1ns/10ps
`default_nettype none
module cpu_model (
    input wire logic clk,
    output logic [7:0] address,
    output logic read,
    output logic write,
    output logic [31:0] writedata,
    output logic [3:0] byteenable,
    input wire logic [31:0] readdata,
    input wire logic waitrequest
);
    logic intEnable = 1'b1;
    initial begin
        address = 8'h00;
        read = 1'b0;
        write = 1'b0;
        writedata = 32'h0000_0000;
        byteenable = 4'hF;
    end
    ////////////////////////////////////////////////////////////
    // Extra edge at the end so a following call never re-drives in one step
    task automatic wrbe(input logic [7:0] a, input logic [31:0] d, input logic [3:0] be);
        address <= a;
        writedata <= d;
        byteenable <= be;
        write <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        write <= 1'b0;
        @(posedge clk);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        wrbe(a, d, 4'hF);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        address <= a;
        read <= 1'b1;
        do @(posedge clk); while (waitrequest !== 1'b0);
        d = readdata;
        read <= 1'b0;
        @(posedge clk);
    endtask
    // Plain store only: the clear location cannot be read back
    task automatic clr(input logic [7:0] code);
        intEnable = 1'b0;
        wr(wakeup_clear_pkg::ADDR_CLEAR, {24'h00_0000, code});
        intEnable = 1'b1;
    endtask
endmodule // cpu_model
`default_nettype wire

// ===== verification/tb_top.sv
// Bench for wake input seven edge modes, flag clear and status/mask.
// Assumes the package and the design are compiled first.
`timescale 1ns/10ps
`default_nettype none
module tb_top;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic pin = 1'b0;
    logic ce = 1'h1;
    logic [3:0] src = 4'h0;
    logic [7:0] address;
    logic read, write, waitrequest, wakeReq, irq;
    logic [31:0] writedata, readdata, rdata;
    logic [3:0] byteenable, pend;
    int errorCnt = 0, nChecks = 0, cyc = 0, pulses = 0;
    always #25 clk = ~clk;
    always @(posedge clk) begin
        cyc++;
        if (wakeReq === 1'b1) pulses++;
        if (cyc == 4000) begin
            errorCnt++;
            summarize();
        end
    end
    wakeup_edge_and_flag_clear wakeup_edge_and_flag_clear_inst (.clk(clk), .rst_n(rst_n), .ce(ce),
        .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .wakeInputPinSeven(pin), .srcRequest(src),
        .pendingFlags(pend), .wakeupRequestSeven(wakeReq), .irq(irq));
    cpu_model cpu_model_inst (.clk(clk), .address(address), .read(read), .write(write),
        .writedata(writedata), .byteenable(byteenable), .readdata(readdata), .waitrequest(waitrequest));
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        nChecks++;
        if (got !== exp) begin
            errorCnt++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic rdchk(input logic [7:0] a, input logic [31:0] exp);
        cpu_model_inst.rd(a, rdata);
        chk(rdata, exp);
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", nChecks, errorCnt);
        if (errorCnt == 0 && nChecks > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    task automatic test_edges();
        for (int k = 0; k < 3; k++) begin
            cpu_model_inst.wr(wakeup_clear_pkg::ADDR_MODE, (k == 0) ? 32'h0 : 32'h80);
            cpu_model_inst.wr(wakeup_clear_pkg::ADDR_EDGE, (k == 2) ? 32'h80 : 32'h0);
            pulses = 0;
            pin <= 1'b1;
            repeat (8) @(posedge clk);
            chk(pulses, (k != 1) ? 1 : 0);
            pin <= 1'b0;
            repeat (8) @(posedge clk);
            chk(pulses, (k == 0) ? 2 : 1);
        end
        rdchk(wakeup_clear_pkg::ADDR_MODE, 32'h80);
        rdchk(wakeup_clear_pkg::ADDR_EDGE, 32'h80);
    endtask
    task automatic test_irq();
        rdchk(wakeup_clear_pkg::ADDR_STAT, 32'h1);
        chk(irq, 1'b0);
        cpu_model_inst.wr(wakeup_clear_pkg::ADDR_MASK, 32'h1);
        chk(irq, 1'b1);
        // Lane zero off: the write is acknowledged and ignored
        cpu_model_inst.wrbe(wakeup_clear_pkg::ADDR_MASK, 32'h0, 4'hE);
        chk(irq, 1'h1);
        rdchk(wakeup_clear_pkg::ADDR_MASK, 32'h1);
        cpu_model_inst.wr(wakeup_clear_pkg::ADDR_STAT, 32'h1);
        chk(irq, 1'b0);
        rdchk(wakeup_clear_pkg::ADDR_STAT, 32'h0);
    endtask
    task automatic test_clear();
        src <= 4'hF;
        @(posedge clk);
        src <= 4'h0;
        @(posedge clk);
        chk(pend, 4'hF);
        rdchk(wakeup_clear_pkg::ADDR_PEND, 32'hF);
        cpu_model_inst.clr(8'h55);
        chk(pend, 4'hF);
        rdchk(wakeup_clear_pkg::ADDR_STAT, 32'h2);
        cpu_model_inst.clr(wakeup_clear_pkg::VEC_EXT_ZERO);
        chk(pend, 4'hE);
        for (int k = 1; k < 4; k++) begin
            cpu_model_inst.clr(8'(8'h0A + k));
            chk(pend, 4'(4'hF << (k + 1)));
        end
        // Request pulse in the clearing cycle must survive the clear
        src <= 4'h1;
        fork
            cpu_model_inst.clr(wakeup_clear_pkg::VEC_EXT_ZERO);
            begin
                @(posedge clk);
                src <= 4'h0;
            end
        join
        chk(pend, 4'h1);
        cpu_model_inst.clr(wakeup_clear_pkg::VEC_EXT_ZERO);
        chk(pend, 4'h0);
        rdchk(wakeup_clear_pkg::ADDR_CLEAR, 32'h0);
        rdchk(8'h40, 32'h0);
    endtask
    // Rising mode is left set; a pin edge under low enable waits for it
    task automatic test_freeze();
        pulses = 0;
        ce <= 1'h0;
        pin <= 1'h1;
        repeat (8) @(posedge clk);
        chk(pulses, 0);
        chk(pend, 4'h0);
        chk(irq, 1'h0);
        ce <= 1'h1;
        repeat (8) @(posedge clk);
        chk(pulses, 1);
        chk(pend, 4'h2);
        chk(irq, 1'h1);
    endtask
    initial begin
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
        @(posedge clk);
        rdchk(wakeup_clear_pkg::ADDR_MODE, 32'h0);
        rdchk(wakeup_clear_pkg::ADDR_MASK, 32'h0);
        test_edges();
        test_irq();
        test_clear();
        test_freeze();
        summarize();
    end
endmodule // tb_top
`default_nettype wire
